// ### design/swr_pkg.sv
// Constants for the sleep/wake and reversal sequencer.
// Assumes one 100 MHz clock; times count in 10 ms ticks.
package swr_pkg;
	// Clock and tick timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 10_000_000;
	localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
	// Ticks in one 0.1 s setting step
	localparam logic [19:0] DECI_TICKS = 20'h0000A;
	// Register byte offsets
	localparam logic [7:0] A_ACTION = 8'h00;
	localparam logic [7:0] A_WAKE = 8'h04;
	localparam logic [7:0] A_SLEEP = 8'h08;
	localparam logic [7:0] A_SWMODE = 8'h0C;
	localparam logic [7:0] A_DEADZ = 8'h10;
	localparam logic [7:0] A_STOPSPD = 8'h14;
	localparam logic [7:0] A_DETWAIT = 8'h18;
	localparam logic [7:0] A_STARTF = 8'h1C;
	localparam logic [7:0] A_HOLD = 8'h20;
	localparam logic [7:0] A_LOWLIM = 8'h24;
	localparam logic [7:0] A_CTRL = 8'h28;
	localparam logic [7:0] A_STATUS = 8'h2C;
	// Field positions
	localparam int ACT_TENS_LSB = 4;
	localparam int SW_SRC_BIT = 4;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_BRK = 2;
	// Reset values
	localparam logic [7:0] ACTION_RST = 8'h00;
	localparam logic [1:0] SWMODE_RST = 2'h1;
	localparam logic [15:0] STOPSPD_RST = 16'h0032;
	localparam logic [15:0] DETWAIT_RST = 16'h0032;
	localparam logic [15:0] STARTF_RST = 16'h0032;
	localparam logic [15:0] TIME_RST = 16'h0000;
	// Action and stop-style codes
	localparam logic [3:0] ACT_RUN_LOW = 4'h0;
	localparam logic [3:0] ACT_STOP = 4'h1;
	localparam logic [3:0] ACT_SLEEP = 4'h2;
	localparam logic [3:0] STOP_COAST = 4'h0;
	// Direction switch modes
	localparam logic [1:0] SW_ZERO = 2'h0;
	localparam logic [1:0] SW_DELAY = 2'h2;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_HOLD = 4'h1,
		S_RUN = 4'h2,
		S_STOP = 4'h3,
		S_SLEEP = 4'h4,
		S_DEC = 4'h5,
		S_DETW = 4'h6,
		S_BRAKE = 4'h7,
		S_DEAD = 4'h8
	} swr_state_e;
endpackage

// ### design/swr_sequencer.sv
// Sleep/wake and forward/reverse sequencer with AXI4-Lite settings.
// Assumes a ramp generator follows ramp_target and reports out_freq;
// frequencies in 0.01 Hz, all inputs synchronous to aclk.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module swr_sequencer
	import swr_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] freq_cmd,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] fb_freq,
	input wire logic brake_done,
	output logic [15:0] ramp_target,
	output logic ramp_coast,
	output logic run_reverse,
	output logic dc_brake_req
);
	////////////////////////////////////////////////////////////////////
	// Settings registers
	logic [7:0] action_q; // below_limit_action_select
	logic [15:0] wake_q; // wake_delay_time, 0.1 s
	logic [15:0] sleep_q; // sleep_delay_time, 0.1 s
	logic [1:0] swmode_q; // direction_switch_mode
	logic src_q; // stop_speed_detect_source
	logic [15:0] deadz_q; // direction_deadzone_time, 0.1 s
	logic [15:0] stopspd_q; // stop_speed_threshold
	logic [15:0] detw_q; // stop_speed_detect_wait, 0.01 s
	logic [15:0] startf_q; // starting_frequency
	logic [15:0] hold_q; // starting_frequency_hold_time, 0.1 s
	logic [15:0] lowlim_q; // Frequency lower limit
	logic [2:0] ctrl_q; // Run, direction request, brake enable
	swr_state_e st_q, st_d;
	logic dir_q; // Present direction, 1 = reverse_direction
	logic to_sleep_q; // Stop ends in sleep rather than standby
	logic [19:0] tmr_q; // Elapsed ticks in present wait
	logic [19:0] lim; // Ticks the present wait needs
	logic tmr_run, tmr_done;
	logic [31:0] pre_q; // Tick prescaler
	logic tick;
	// AXI handshake state
	logic aw_got_q, w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;

	// Scale a 0.1 s setting to ticks; width kept at 20 bits on purpose
	function automatic logic [19:0] deci(input logic [15:0] v);
		deci = 20'(20'(v) * DECI_TICKS);
	endfunction

	// Word-select of the write data under byte strobes
	function automatic logic [15:0] wr16(input logic [15:0] old);
		wr16 = {s_axi_wstrb[1] ? wdata_q[15:8] : old[15:8],
			s_axi_wstrb[0] ? wdata_q[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order
	logic wr_fire;
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready = !w_got_q && !s_axi_bvalid;
	assign wr_fire = aw_got_q && w_got_q;

	// Capture address and data, then answer once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Status and holes refuse writes
				s_axi_bresp <= (awaddr_q > A_CTRL || awaddr_q[1:0] != 2'h0)
					? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Settings update; a write lands on the same edge that raises bvalid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			action_q <= ACTION_RST;
			wake_q <= TIME_RST;
			sleep_q <= TIME_RST;
			swmode_q <= SWMODE_RST;
			src_q <= 1'b0;
			deadz_q <= TIME_RST;
			stopspd_q <= STOPSPD_RST;
			detw_q <= DETWAIT_RST;
			startf_q <= STARTF_RST;
			hold_q <= TIME_RST;
			lowlim_q <= 16'h0000;
			ctrl_q <= 3'h0;
		end else if (wr_fire) begin
			case (awaddr_q)
				A_ACTION: if (s_axi_wstrb[0]) action_q <= wdata_q[7:0];
				A_WAKE: wake_q <= wr16(wake_q);
				A_SLEEP: sleep_q <= wr16(sleep_q);
				A_SWMODE: if (s_axi_wstrb[0]) begin
					swmode_q <= wdata_q[1:0];
					src_q <= wdata_q[SW_SRC_BIT];
				end
				A_DEADZ: deadz_q <= wr16(deadz_q);
				A_STOPSPD: stopspd_q <= wr16(stopspd_q);
				A_DETWAIT: detw_q <= wr16(detw_q);
				A_STARTF: startf_q <= wr16(startf_q);
				A_HOLD: hold_q <= wr16(hold_q);
				A_LOWLIM: lowlim_q <= wr16(lowlim_q);
				A_CTRL: if (s_axi_wstrb[0]) ctrl_q <= wdata_q[2:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path: one-cycle registered answer
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				A_ACTION: s_axi_rdata <= {24'h000000, action_q};
				A_WAKE: s_axi_rdata <= {16'h0000, wake_q};
				A_SLEEP: s_axi_rdata <= {16'h0000, sleep_q};
				A_SWMODE: s_axi_rdata <= {27'h0, src_q, 2'h0, swmode_q};
				A_DEADZ: s_axi_rdata <= {16'h0000, deadz_q};
				A_STOPSPD: s_axi_rdata <= {16'h0000, stopspd_q};
				A_DETWAIT: s_axi_rdata <= {16'h0000, detw_q};
				A_STARTF: s_axi_rdata <= {16'h0000, startf_q};
				A_HOLD: s_axi_rdata <= {16'h0000, hold_q};
				A_LOWLIM: s_axi_rdata <= {16'h0000, lowlim_q};
				A_CTRL: s_axi_rdata <= {29'h0, ctrl_q};
				// Live sequencer state for software
				A_STATUS: s_axi_rdata <= {26'h0, to_sleep_q, dir_q, st_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Tick prescaler: one tick per 10 ms
	assign tick = (pre_q == TICK_CYC - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			pre_q <= 32'h00000000;
		else
			pre_q <= pre_q + 32'h00000001;
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer decisions
	logic run_req, dir_req, below, above, turn;
	logic [3:0] act, style;
	logic [15:0] point, spd;
	assign run_req = ctrl_q[CTRL_RUN];
	assign dir_req = ctrl_q[CTRL_DIR];
	assign act = action_q[3:0];
	assign style = action_q[ACT_TENS_LSB +: 4];
	// Lower limit of zero disables the below-limit action
	assign below = (lowlim_q != 16'h0000) && (freq_cmd < lowlim_q);
	assign above = freq_cmd > lowlim_q;
	assign turn = dir_req != dir_q;
	// Switch point: stop speed in mode 0, start frequency else
	assign point = (swmode_q == SW_ZERO) ? stopspd_q : startf_q;
	assign spd = src_q ? fb_freq : out_freq;
	assign tmr_done = tmr_q >= lim;

	// Next state, timer enable and the timer's goal
	always_comb begin
		st_d = st_q;
		tmr_run = 1'b0;
		lim = 20'h00000;
		case (st_q)
			S_IDLE: begin
				// Command under start frequency keeps standby
				if (run_req && freq_cmd >= startf_q) st_d = S_HOLD;
			end
			S_HOLD: begin
				tmr_run = 1'b1;
				lim = deci(hold_q);
				if (!run_req) st_d = S_STOP;
				else if (tmr_done) st_d = S_RUN;
			end
			S_RUN: begin
				lim = deci(sleep_q);
				if (!run_req) begin
					st_d = S_STOP;
				end else if (turn) begin
					st_d = S_DEC;
				end else if (below && act == ACT_STOP) begin
					st_d = S_STOP;
				end else if (below && act == ACT_SLEEP) begin
					// Timer clears as soon as command recovers
					tmr_run = 1'b1;
					if (tmr_done) st_d = S_STOP;
				end
			end
			S_STOP: begin
				// Coast ends at once; decel waits for stop speed
				if (style == STOP_COAST || spd <= stopspd_q)
					st_d = to_sleep_q ? S_SLEEP : S_IDLE;
			end
			S_SLEEP: begin
				lim = deci(wake_q);
				if (!run_req) begin
					st_d = S_IDLE;
				end else if (above) begin
					tmr_run = 1'b1;
					if (tmr_done) st_d = S_HOLD;
				end
			end
			S_DEC: begin
				if (swmode_q == SW_DELAY) begin
					// Normal stop to stop speed on the chosen source
					if (spd <= stopspd_q)
						st_d = ctrl_q[CTRL_BRK] ? S_BRAKE : S_DEAD;
				end else if (out_freq <= point) begin
					// Feedback still fast: detection wait first
					if (src_q && fb_freq >= point) st_d = S_DETW;
					else st_d = S_DEAD;
				end
			end
			S_DETW: begin
				tmr_run = 1'b1;
				lim = {4'h0, detw_q};
				if (tmr_done) st_d = S_DEAD;
			end
			S_BRAKE: begin
				if (brake_done) st_d = S_DEAD;
			end
			S_DEAD: begin
				tmr_run = 1'b1;
				lim = deci(deadz_q);
				if (tmr_done) st_d = S_RUN;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// State, direction and sleep intent
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE;
			dir_q <= 1'b0;
			to_sleep_q <= 1'b0;
		end else begin
			st_q <= st_d;
			// New start takes the requested direction
			if (st_q == S_IDLE && st_d == S_HOLD) dir_q <= dir_req;
			// Reverse only after the deadzone has elapsed
			if (st_q == S_DEAD && st_d == S_RUN) dir_q <= ~dir_q;
			if (st_q == S_RUN && st_d == S_STOP)
				to_sleep_q <= run_req && act == ACT_SLEEP;
			else if (st_q == S_SLEEP)
				to_sleep_q <= 1'b0;
		end
	end

	// Wait timer; restarts on every state change
	always_ff @(posedge aclk) begin
		if (!aresetn || !tmr_run || st_d != st_q)
			tmr_q <= 20'h00000;
		else if (tick && !tmr_done)
			tmr_q <= tmr_q + 20'h00001;
	end

	////////////////////////////////////////////////////////////////////
	// Registered drive outputs for the ramp and inverter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ramp_target <= 16'h0000;
			ramp_coast <= 1'b1;
			dc_brake_req <= 1'b0;
			run_reverse <= 1'b0;
		end else begin
			run_reverse <= dir_q;
			dc_brake_req <= st_q == S_BRAKE;
			ramp_coast <= st_q == S_IDLE || st_q == S_SLEEP
				|| (st_q == S_STOP && style == STOP_COAST);
			case (st_q)
				S_HOLD: ramp_target <= startf_q;
				S_RUN: ramp_target <= below ? lowlim_q : freq_cmd;
				S_DEC: ramp_target <= swmode_q == SW_DELAY
					? 16'h0000 : point;
				default: ramp_target <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_standby;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_IDLE && freq_cmd < startf_q |=> st_q == S_IDLE;
	endproperty
	a_standby: assert property (p_standby)
		else $error("started below starting frequency");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_HOLD |=> ramp_target == $past(startf_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold target is not starting frequency");

	property p_run_low;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_RUN && below && act == ACT_RUN_LOW && run_req && !turn
		|=> st_q == S_RUN ##0 ramp_target == $past(lowlim_q);
	endproperty
	a_run_low: assert property (p_run_low)
		else $error("not held at lower limit");

	property p_sleep_wait;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_RUN && st_d == S_STOP && run_req && below
		&& act == ACT_SLEEP |-> tmr_q >= deci(sleep_q);
	endproperty
	a_sleep_wait: assert property (p_sleep_wait)
		else $error("sleep entered before delay");

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_SLEEP ##1 st_q == S_HOLD |-> $past(above && tmr_done);
	endproperty
	a_wake: assert property (p_wake)
		else $error("woke without qualified delay");

	property p_coast;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_STOP && style == STOP_COAST |=> ramp_coast;
	endproperty
	a_coast: assert property (p_coast)
		else $error("coast stop kept drive on");

	property p_dead_hold;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_DEAD && !tmr_done |=> st_q == S_DEAD && dir_q == $past(dir_q);
	endproperty
	a_dead_hold: assert property (p_dead_hold)
		else $error("reversed inside deadzone");

	property p_flip;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_DEAD && tmr_done |=> st_q == S_RUN ##1 run_reverse == dir_q;
	endproperty
	a_flip: assert property (p_flip)
		else $error("no reversal after deadzone");

	property p_detw;
		@(posedge aclk) disable iff (!aresetn)
		st_q == S_DEC ##1 st_q == S_DETW |-> $past(src_q && fb_freq >= point);
	endproperty
	a_detw: assert property (p_detw)
		else $error("detect wait without fast feedback");

	property p_bhold;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");

	c_sleep: cover property (@(posedge aclk) st_q == S_SLEEP ##1 st_q == S_HOLD);
	c_detw: cover property (@(posedge aclk) st_q == S_DETW ##1 st_q == S_DEAD);
	c_brake: cover property (@(posedge aclk) st_q == S_BRAKE ##1 st_q == S_DEAD);
endmodule

// ### verif/swr_ramp_model.sv
// Behavioural model of the ramp generator and inverter stage.
// Assumes ramp_target, ramp_coast and dc_brake_req change on aclk only.
`timescale 1ns/100ps
module swr_ramp_model
	import swr_pkg::*;
#(
	parameter logic [15:0] STEP = 16'h0019,
	parameter int BRK_CYC = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] ramp_target,
	input wire logic ramp_coast,
	input wire logic dc_brake_req,
	output logic [15:0] out_freq,
	output logic [15:0] fb_freq,
	output logic brake_done
);
	// Goal of the ramp: zero while coasting, else the target
	logic [15:0] goal;
	// Cycles spent braking so far
	int brk_cnt;

	assign goal = ramp_coast ? 16'h0000 : ramp_target;

	////////////////////////////////////////////////////////////////////
	// Output frequency walks towards the goal by a fixed step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_freq <= 16'h0000;
		end else if (out_freq > goal) begin
			out_freq <= (out_freq - goal > STEP) ? out_freq - STEP : goal;
		end else begin
			out_freq <= (goal - out_freq > STEP) ? out_freq + STEP : goal;
		end
	end

	// Measured speed lags the output by one cycle, as a real sensor would
	always_ff @(posedge aclk) begin
		fb_freq <= aresetn ? out_freq : 16'h0000;
	end

	////////////////////////////////////////////////////////////////////
	// Braking finishes only after a fixed time, never at once
	always_ff @(posedge aclk) begin
		if (!aresetn || !dc_brake_req) begin
			brk_cnt <= 0;
			brake_done <= 1'b0;
		end else begin
			brk_cnt <= brk_cnt + 1;
			brake_done <= (brk_cnt >= BRK_CYC);
		end
	end
endmodule

// ### verif/tb_sleep_wake_and_reversal_sequencer.sv
// Self-checking bench for the sleep/wake and reversal sequencer.
// Assumes the ramp model stands on the drive side; settings over AXI4-Lite.
`timescale 1ns/100ps
module tb_sleep_wake_and_reversal_sequencer
	import swr_pkg::*;
;
	// Shortened tick so one 0.1 s step is 40 cycles
	localparam int TCK = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h00000000;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [15:0] freq_cmd = 16'h0000;
	logic [15:0] out_freq;
	logic [15:0] fb_freq;
	logic brake_done;
	logic [15:0] ramp_target;
	logic ramp_coast;
	logic run_reverse;
	logic dc_brake_req;
	int errors = 0;
	int total_checks = 0;
	logic [31:0] rd;

	swr_sequencer #(.TICK_CYC(TCK)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .freq_cmd(freq_cmd), .out_freq(out_freq),
		.fb_freq(fb_freq), .brake_done(brake_done),
		.ramp_target(ramp_target), .ramp_coast(ramp_coast),
		.run_reverse(run_reverse), .dc_brake_req(dc_brake_req));

	swr_ramp_model drive (.aclk(aclk), .aresetn(aresetn),
		.ramp_target(ramp_target), .ramp_coast(ramp_coast),
		.dc_brake_req(dc_brake_req), .out_freq(out_freq), .fb_freq(fb_freq),
		.brake_done(brake_done));

	// 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////
	// Report, compare and bus helpers
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A bound ran out: count it and stop
	task automatic hang;
		chk(32'h0, 32'h1);
		give_verdict();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Ready is sampled before the edge, so the edge itself is the transfer
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		logic [1:0] rsp;
		n = 0;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			rsp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
			if (n > 50) hang();
		end
		bready <= 1'b0;
		chk(rsp, er);
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] exp,
			input logic [1:0] er, input logic cmp);
		int n;
		logic ta, tr;
		logic [1:0] rsp;
		n = 0;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			rd = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			n++;
			if (n > 50) hang();
		end
		rready <= 1'b0;
		chk(rsp, er);
		if (cmp) chk(rd, exp);
	endtask

	// Read the state field only
	task automatic state_is(input logic [3:0] s);
		axr(A_STATUS, 32'h0, RESP_OKAY, 1'b0);
		chk(rd[3:0], s);
	endtask

	task automatic wait_tgt(input logic [15:0] v, output int n);
		n = 0;
		while (ramp_target !== v) begin
			cyc(1);
			n++;
			if (n > 600) hang();
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		chk(ramp_target, 32'h0);
		chk(ramp_coast, 32'h1);
		chk(run_reverse, 32'h0);
		axr(A_ACTION, 32'h00, RESP_OKAY, 1'b1);
		axr(A_SWMODE, 32'h01, RESP_OKAY, 1'b1);
		axr(A_STOPSPD, 32'h32, RESP_OKAY, 1'b1);
		axr(A_DEADZ, 32'h00, RESP_OKAY, 1'b1);
		axr(8'h30, 32'h00, RESP_SLVERR, 1'b1);
		axw(A_STATUS, 32'h1, RESP_SLVERR);
		axw(8'h06, 32'h1, RESP_SLVERR);
		// Starting point 2.00 Hz keeps it apart from the stop speed
		axw(A_STARTF, 32'hC8, RESP_OKAY);
		axw(A_HOLD, 32'h2, RESP_OKAY);
		axw(A_DEADZ, 32'h1, RESP_OKAY);
		axw(A_DETWAIT, 32'h14, RESP_OKAY);
	endtask

	// Standby below the starting point, then hold and ramp up
	task automatic t_start;
		int n;
		freq_cmd <= 16'd100;
		axw(A_CTRL, 32'h1, RESP_OKAY);
		cyc(60);
		chk(ramp_coast, 32'h1);
		state_is(S_IDLE);
		freq_cmd <= 16'd1000;
		cyc(40);
		chk(ramp_target, 32'd200);
		chk(ramp_coast, 32'h0);
		wait_tgt(16'd1000, n);
		chk(n >= 30, 32'h1);
	endtask

	// Count cycles spent at or under the switch point before the flip
	task automatic t_reverse(input logic [31:0] sw, input logic [31:0] ctl,
			input logic [15:0] pt, input logic brk_exp, input int lo);
		int n, cnt;
		logic brk;
		logic [15:0] tgt;
		n = 0;
		cnt = 0;
		brk = 1'b0;
		tgt = 16'h0000;
		cyc(150);
		axw(A_SWMODE, sw, RESP_OKAY);
		axw(A_CTRL, ctl, RESP_OKAY);
		while (run_reverse !== ctl[1]) begin
			cyc(1);
			if (out_freq <= pt) cnt++;
			// Slowdown goal seen between the two run targets
			if (ramp_target != 16'h0000 && ramp_target < 16'd1000) begin
				tgt = ramp_target;
			end
			brk |= dc_brake_req;
			n++;
			if (n > 3000) hang();
		end
		chk(cnt >= lo, 32'h1);
		chk(tgt, sw[1] ? 16'h0000 : pt);
		chk(brk, brk_exp);
	endtask

	task automatic t_below;
		int n;
		axw(A_CTRL, 32'h3, RESP_OKAY);
		axw(A_LOWLIM, 32'd500, RESP_OKAY);
		axw(A_SLEEP, 32'h1, RESP_OKAY);
		axw(A_WAKE, 32'h1, RESP_OKAY);
		axw(A_ACTION, 32'h00, RESP_OKAY);
		freq_cmd <= 16'd300;
		cyc(30);
		chk(ramp_target, 32'd500);
		axw(A_ACTION, 32'h12, RESP_OKAY);
		cyc(20);
		state_is(S_RUN);
		n = 0;
		rd = 32'h0;
		// Decelerating stop must keep the inverter on until asleep
		while (rd[3:0] !== S_SLEEP) begin
			axr(A_STATUS, 32'h0, RESP_OKAY, 1'b0);
			if (rd[3:0] === S_STOP) chk(ramp_coast, 32'h0);
			n++;
			if (n > 100) hang();
		end
		chk(ramp_coast, 32'h1);
		// Interrupted wake condition must restart the delay
		freq_cmd <= 16'd800;
		cyc(25);
		freq_cmd <= 16'd300;
		cyc(3);
		freq_cmd <= 16'd800;
		cyc(25);
		state_is(S_SLEEP);
		wait_tgt(16'd800, n);
		// Coasting stop action
		axw(A_ACTION, 32'h01, RESP_OKAY);
		freq_cmd <= 16'd300;
		n = 0;
		while (ramp_coast !== 1'b1) begin
			cyc(1);
			n++;
			if (n > 200) hang();
		end
		axr(A_STATUS, 32'h0, RESP_OKAY, 1'b0);
		chk(rd[3:0] === S_SLEEP, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_start();
		t_reverse(32'h10, 32'h3, 16'd50, 1'b0, 110);
		t_reverse(32'h01, 32'h1, 16'd200, 1'b0, 36);
		t_reverse(32'h02, 32'h7, 16'd50, 1'b1, 50);
		t_below();
		give_verdict();
	end
endmodule
